// *** src/arl_pkg.sv ***
// Constants, register map and state codes of the rate-adaptive ARQ link
`default_nettype none
package arl_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W  = 5;
  localparam int FLT_W  = 8;
  localparam int TRY_W  = 4;
  localparam int ERR_W  = 3;
  localparam int FUZ_W  = 2;
  localparam int CALL_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BC_W   = 8;
  localparam int BC_D   = 4;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DOWN   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_UP     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TRIES  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TMO    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FUZZ   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_REMOTE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_OWN    = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;

  // Control and command bits
  localparam int CTRL_MON  = 0;
  localparam int CTRL_MBOX = 1;
  localparam int CMD_GO    = 0;
  localparam int CMD_CALL  = 1;
  localparam int CMD_DISC  = 2;
  localparam int CMD_EXIT  = 3;
  localparam int CMD_MON   = 4;

  // ****************************************************************
  // Settings: defaults and legal ranges
  // ****************************************************************
  localparam logic [7:0] DOWN_DEF  = 8'h06;
  localparam logic [7:0] DOWN_MIN  = 8'h02;
  localparam logic [7:0] DOWN_MAX  = 8'h1e;
  localparam logic [7:0] UP_DEF    = 8'h03;
  localparam logic [7:0] UP_MIN    = 8'h02;
  localparam logic [7:0] UP_MAX    = 8'h1e;
  localparam logic [7:0] TRIES_DEF = 8'h02;
  localparam logic [7:0] TRIES_MIN = 8'h00;
  localparam logic [7:0] TRIES_MAX = 8'h09;
  localparam logic [7:0] TMO_DEF   = 8'h28;
  localparam logic [7:0] TMO_MIN   = 8'h1e;
  localparam logic [7:0] TMO_MAX   = 8'hff;
  localparam logic [7:0] FUZZ_DEF  = 8'h03;
  localparam logic [7:0] FUZZ_MIN  = 8'h00;
  localparam logic [7:0] FUZZ_MAX  = 8'h03;

  // ****************************************************************
  // Symbol rates
  // ****************************************************************
  localparam logic [1:0] RATE_100 = 2'h0;
  localparam logic [1:0] RATE_200 = 2'h1;
  localparam logic [1:0] RATE_300 = 2'h2;
  localparam logic [1:0] RATE_ONE = 2'h1;

  // ****************************************************************
  // Mode states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_CMD     = 5'h01,
    ST_STANDBY = 5'h02,
    ST_LINKING = 5'h04,
    ST_LINKED  = 5'h08,
    ST_MONITOR = 5'h10
  } arl_state_e;

endpackage
`default_nettype wire

// *** src/arl_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`default_nettype none
module arl_fifo
  import arl_pkg::*;
#(
  parameter int W = BC_W,
  parameter int D = BC_D
)
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int PW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [W-1:0]  mem_d [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] wp_d;
  logic [PW-1:0] rp_q;
  logic [PW-1:0] rp_d;
  logic [PW:0]   cnt_q;
  logic [PW:0]   cnt_d;
  logic          push;
  logic          pop;

  // Honest flags: full stalls the filler, empty hides stale words
  assign in_ready  = (cnt_q != (PW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wp_q] = in_data;
      wp_d        = (wp_q == PW'(D-1)) ? '0 : wp_q + PW'(1);
    end
    if (pop)
    begin
      rp_d = (rp_q == PW'(D-1)) ? '0 : rp_q + PW'(1);
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + (PW+1)'(1);
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - (PW+1)'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < D; i++)
      begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// *** src/arl_link_ctrl.sv ***
// Rate-adaptive ARQ link controller: modes, rate steps, timeouts
// What this block does
// - Step rate down one level after set count of consecutive bad frames.
// - Try to step rate up one level after the set count of good frames.
// - Limit rate-raise attempts to a set maximum of zero to nine.
// - When attempts run out, go back to the old rate until good count again.
// - Linking gives up to standby after set count of unanswered attempts.
// - Linked, that same count of consecutive faulty frames is a timeout.
// - Accept an acknowledgement only if its corrupted bits are within limit.
// - Standby answers calls to own callsign, sends and monitors broadcasts.
// - Link command with a callsign starts a link attempt to that station.
// - Disconnect returns to standby; exit returns to command state.
// - Mailbox control owns the transmitter and refuses manual transmit.
// - Receive-only monitor state; exit returns to command state.
//
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none
module arl_link_ctrl
  import arl_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  // Frames from the remote modem
  input  wire logic              frame_valid,
  input  wire logic              frame_good,
  input  wire logic              ack_valid,
  input  wire logic [ERR_W-1:0]  ack_err_bits,
  input  wire logic              rate_up_ok,
  input  wire logic              rate_up_fail,
  // Link setup events
  input  wire logic              link_req_valid,
  input  wire logic [CALL_W-1:0] link_req_call,
  input  wire logic              link_resp,
  input  wire logic              attempt_miss,
  // Broadcast receive path
  input  wire logic              bcast_in_valid,
  input  wire logic [BC_W-1:0]   bcast_in_data,
  output logic                   bcast_in_ready,
  output logic                   bcast_out_valid,
  output logic [BC_W-1:0]        bcast_out_data,
  input  wire logic              bcast_out_ready,
  // Transmit control
  input  wire logic              manual_tx_req,
  output logic                   manual_tx_grant,
  output logic                   mailbox_tx_owner,
  output logic                   bcast_tx_allowed,
  // Link status
  output logic [1:0]             link_rate,
  output logic [4:0]             link_state,
  output logic [CALL_W-1:0]      remote_call_out,
  output logic                   ack_accept,
  output logic                   link_timeout
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  function automatic logic [7:0] clampv(input logic [DATA_W-1:0] v,
                                        input logic [7:0]        lo,
                                        input logic [7:0]        hi);
    logic [7:0] r;
    r = (v < DATA_W'(lo)) ? lo : (v > DATA_W'(hi)) ? hi : v[7:0];
    return r;
  endfunction

  logic              mon_en_q,  mon_en_d;
  logic              mbox_q,    mbox_d;
  logic [CNT_W-1:0]  down_q,    down_d;
  logic [CNT_W-1:0]  up_q,      up_d;
  logic [TRY_W-1:0]  lim_q,     lim_d;
  logic [FLT_W-1:0]  tmo_q,     tmo_d;
  logic [FUZ_W-1:0]  fuzz_q,    fuzz_d;
  logic [CALL_W-1:0] remote_q,  remote_d;
  logic [CALL_W-1:0] own_q,     own_d;
  logic [DATA_W-1:0] rdata_q,   rdata_d;
  logic [DATA_W-1:0] status_w;

  // Out-of-range settings are pinned to the nearest legal value
  always_comb
  begin
    mon_en_d = mon_en_q;
    mbox_d   = mbox_q;
    down_d   = down_q;
    up_d     = up_q;
    lim_d    = lim_q;
    tmo_d    = tmo_q;
    fuzz_d   = fuzz_q;
    remote_d = remote_q;
    own_d    = own_q;
    rdata_d  = '0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFF_CTRL:
        begin
          mon_en_d = reg_wdata[CTRL_MON];
          mbox_d   = reg_wdata[CTRL_MBOX];
        end
        OFF_DOWN:   down_d   = CNT_W'(clampv(reg_wdata, DOWN_MIN, DOWN_MAX));
        OFF_UP:     up_d     = CNT_W'(clampv(reg_wdata, UP_MIN, UP_MAX));
        OFF_TRIES:  lim_d    = TRY_W'(clampv(reg_wdata, TRIES_MIN,
                                             TRIES_MAX));
        OFF_TMO:    tmo_d    = FLT_W'(clampv(reg_wdata, TMO_MIN, TMO_MAX));
        OFF_FUZZ:   fuzz_d   = FUZ_W'(clampv(reg_wdata, FUZZ_MIN, FUZZ_MAX));
        OFF_REMOTE: remote_d = reg_wdata;
        OFF_OWN:    own_d    = reg_wdata;
        default:    ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFF_CTRL:   rdata_d = DATA_W'({mbox_q, mon_en_q});
        OFF_DOWN:   rdata_d = DATA_W'(down_q);
        OFF_UP:     rdata_d = DATA_W'(up_q);
        OFF_TRIES:  rdata_d = DATA_W'(lim_q);
        OFF_TMO:    rdata_d = DATA_W'(tmo_q);
        OFF_FUZZ:   rdata_d = DATA_W'(fuzz_q);
        OFF_REMOTE: rdata_d = remote_q;
        OFF_OWN:    rdata_d = own_q;
        OFF_STATUS: rdata_d = status_w;
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_en_q <= 1'b0;
      mbox_q   <= 1'b0;
      down_q   <= CNT_W'(DOWN_DEF);
      up_q     <= CNT_W'(UP_DEF);
      lim_q    <= TRY_W'(TRIES_DEF);
      tmo_q    <= FLT_W'(TMO_DEF);
      fuzz_q   <= FUZ_W'(FUZZ_DEF);
      remote_q <= '0;
      own_q    <= '0;
      rdata_q  <= '0;
    end
    else
    begin
      mon_en_q <= mon_en_d;
      mbox_q   <= mbox_d;
      down_q   <= down_d;
      up_q     <= up_d;
      lim_q    <= lim_d;
      tmo_q    <= tmo_d;
      fuzz_q   <= fuzz_d;
      remote_q <= remote_d;
      own_q    <= own_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Mode and rate control
  // ****************************************************************
  arl_state_e        state_q, state_d;
  logic [1:0]        rate_q,  rate_d;
  logic [1:0]        prev_q,  prev_d;
  logic              trying_q, trying_d;
  logic [TRY_W-1:0]  tries_q, tries_d;
  logic [CNT_W-1:0]  good_q,  good_d;
  logic [CNT_W-1:0]  bad_q,   bad_d;
  logic [FLT_W-1:0]  fault_q, fault_d;
  logic              ack_q,   ack_d;
  logic              tmo_ev_q, tmo_ev_d;
  logic              cmd_hit;
  logic [CNT_W-1:0]  good_inc;
  logic [CNT_W-1:0]  bad_inc;
  logic [FLT_W-1:0]  fault_inc;
  logic [TRY_W-1:0]  tries_inc;

  assign cmd_hit   = reg_wr && (reg_addr == OFF_CMD);
  assign good_inc  = good_q + CNT_W'(1);
  assign bad_inc   = bad_q + CNT_W'(1);
  assign fault_inc = fault_q + FLT_W'(1);
  assign tries_inc = tries_q + TRY_W'(1);
  assign status_w  = {2'h0, fault_q, bad_q, good_q, tries_q, trying_q,
                      rate_q, state_q};

  always_comb
  begin
    state_d  = state_q;
    rate_d   = rate_q;
    prev_d   = prev_q;
    trying_d = trying_q;
    tries_d  = tries_q;
    good_d   = good_q;
    bad_d    = bad_q;
    fault_d  = fault_q;
    ack_d    = 1'b0;
    tmo_ev_d = 1'b0;
    if (cmd_hit && reg_wdata[CMD_EXIT])
    begin
      state_d = ST_CMD;
    end
    else if (cmd_hit && reg_wdata[CMD_DISC] &&
             (state_q == ST_LINKING || state_q == ST_LINKED))
    begin
      state_d = ST_STANDBY;
    end
    else if (cmd_hit && reg_wdata[CMD_MON] && state_q == ST_CMD)
    begin
      state_d = ST_MONITOR;
    end
    else if (cmd_hit && reg_wdata[CMD_GO] &&
             (state_q == ST_CMD || state_q == ST_STANDBY))
    begin
      fault_d = '0;
      state_d = reg_wdata[CMD_CALL] ? ST_LINKING : ST_STANDBY;
    end
    else
    begin
      unique case (state_q)
        ST_STANDBY:
        begin
          if (link_req_valid && link_req_call == own_q)
          begin
            state_d = ST_LINKED;
          end
        end
        ST_LINKING:
        begin
          if (link_resp)
          begin
            state_d = ST_LINKED;
          end
          else if (attempt_miss)
          begin
            fault_d = fault_inc;
            if (fault_inc >= tmo_q)
            begin
              state_d  = ST_STANDBY;
              tmo_ev_d = 1'b1;
            end
          end
        end
        ST_LINKED:
        begin
          // A failed trial is settled before the frame is counted
          if (trying_q && rate_up_ok)
          begin
            trying_d = 1'b0;
            tries_d  = '0;
          end
          else if (trying_q && rate_up_fail)
          begin
            tries_d = tries_inc;
            if (tries_inc >= lim_q)
            begin
              rate_d   = prev_q;
              trying_d = 1'b0;
              tries_d  = '0;
            end
          end
          if (ack_valid)
          begin
            ack_d = (ack_err_bits <= ERR_W'(fuzz_q));
          end
          if (frame_valid && frame_good)
          begin
            bad_d   = '0;
            fault_d = '0;
            good_d  = good_inc;
            if (good_inc >= up_q)
            begin
              good_d = '0;
              if (rate_d != RATE_300 && !trying_d && lim_q != '0)
              begin
                prev_d   = rate_d;
                rate_d   = rate_d + RATE_ONE;
                trying_d = 1'b1;
              end
            end
          end
          else if (frame_valid)
          begin
            good_d  = '0;
            bad_d   = bad_inc;
            fault_d = fault_inc;
            if (bad_inc >= down_q)
            begin
              bad_d = '0;
              if (rate_d != RATE_100)
              begin
                rate_d   = rate_d - RATE_ONE;
                trying_d = 1'b0;
                tries_d  = '0;
              end
            end
            if (fault_inc >= tmo_q)
            begin
              state_d  = ST_STANDBY;
              tmo_ev_d = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // Each new link starts slow and from clean counts
    if (state_d == ST_LINKED && state_q != ST_LINKED)
    begin
      rate_d   = RATE_100;
      trying_d = 1'b0;
      tries_d  = '0;
      fault_d  = '0;
    end
    if (rate_d != rate_q || (state_d == ST_LINKED && state_q != ST_LINKED))
    begin
      good_d = '0;
      bad_d  = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= ST_CMD;
      rate_q   <= RATE_100;
      prev_q   <= RATE_100;
      trying_q <= 1'b0;
      tries_q  <= '0;
      good_q   <= '0;
      bad_q    <= '0;
      fault_q  <= '0;
      ack_q    <= 1'b0;
      tmo_ev_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      rate_q   <= rate_d;
      prev_q   <= prev_d;
      trying_q <= trying_d;
      tries_q  <= tries_d;
      good_q   <= good_d;
      bad_q    <= bad_d;
      fault_q  <= fault_d;
      ack_q    <= ack_d;
      tmo_ev_q <= tmo_ev_d;
    end
  end

  // ****************************************************************
  // Outputs and broadcast path
  // ****************************************************************
  logic rx_allow;
  logic fifo_in_ready;

  // Standby hears broadcasts only with monitoring on; monitor always
  assign rx_allow = (state_q == ST_STANDBY && mon_en_q) ||
                    state_q == ST_MONITOR;
  assign bcast_in_ready   = rx_allow && fifo_in_ready;
  assign bcast_tx_allowed = (state_q == ST_STANDBY) && !mbox_q;
  assign mailbox_tx_owner = mbox_q;
  assign manual_tx_grant  = manual_tx_req && !mbox_q &&
                            (state_q == ST_STANDBY ||
                             state_q == ST_LINKED);
  assign link_rate        = rate_q;
  assign link_state       = state_q;
  assign remote_call_out  = remote_q;
  assign ack_accept       = ack_q;
  assign link_timeout     = tmo_ev_q;

  arl_fifo #(
    .W (BC_W),
    .D (BC_D)
  ) u_bcast_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (bcast_in_valid && rx_allow),
    .in_data   (bcast_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (bcast_out_valid),
    .out_data  (bcast_out_data),
    .out_ready (bcast_out_ready)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence cmd_wr_s(int b);
    cmd_hit && reg_wdata[b];
  endsequence

  sequence linked_frame_s;
    state_q == ST_LINKED && frame_valid && !cmd_hit && !rate_up_fail;
  endsequence

  rate_down_a: assert property (linked_frame_s and (!frame_good &&
    bad_inc >= down_q && rate_q != RATE_100) |=>
    rate_q == $past(rate_q) - RATE_ONE && bad_q == '0)
    else $error("rate did not step down");
  rate_up_a: assert property (linked_frame_s and (frame_good &&
    !rate_up_ok && good_inc >= up_q && rate_q != RATE_300 && !trying_q &&
    lim_q != '0) |=> rate_q == $past(rate_q) + RATE_ONE && trying_q)
    else $error("rate did not step up");
  try_cap_a: assert property (trying_q && !reg_wr |=>
    tries_q <= lim_q) else $error("too many raise attempts");
  revert_a: assert property (state_q == ST_LINKED && !cmd_hit &&
    trying_q && rate_up_fail && tries_inc >= lim_q && !frame_valid |=>
    rate_q == $past(prev_q) && !trying_q && good_q == '0)
    else $error("no revert after failed raises");
  link_giveup_a: assert property (state_q == ST_LINKING && !cmd_hit &&
    !link_resp && attempt_miss && fault_inc >= tmo_q |=>
    state_q == ST_STANDBY && link_timeout) else $error("no link timeout");
  fault_tmo_a: assert property (linked_frame_s and (!frame_good &&
    fault_inc >= tmo_q) |=> state_q == ST_STANDBY && link_timeout ##1
    !link_timeout) else $error("no linked timeout");
  ack_gate_a: assert property (state_q == ST_LINKED && ack_valid &&
    !cmd_hit |=> ack_accept == ($past(ack_err_bits) <= ERR_W'($past(fuzz_q))))
    else $error("ack tolerance wrong");
  call_in_a: assert property (state_q == ST_STANDBY && !cmd_hit &&
    link_req_valid && link_req_call == own_q |=> state_q == ST_LINKED)
    else $error("own call not answered");
  call_out_a: assert property (cmd_wr_s(CMD_GO) and
    cmd_wr_s(CMD_CALL) and (!reg_wdata[CMD_EXIT] && !reg_wdata[CMD_DISC] &&
    !reg_wdata[CMD_MON] && (state_q == ST_CMD || state_q == ST_STANDBY))
    |=> state_q == ST_LINKING) else $error("link attempt not started");
  exit_cmd_a: assert property (cmd_wr_s(CMD_EXIT) |=>
    state_q == ST_CMD && !bcast_tx_allowed)
    else $error("exit did not reach command state");
  mbox_own_a: assert property (mbox_q |-> !manual_tx_grant &&
    mailbox_tx_owner) else $error("manual transmit under mailbox");
  count_clr_a: assert property (rate_q != $past(rate_q) |->
    good_q == '0 && bad_q == '0) else $error("counters kept over rate change");

endmodule
`default_nettype wire

// *** tb/arl_remote.sv ***
// Remote station model: frame, ack and link events, broadcast bytes
`default_nettype none
module arl_remote
  import arl_pkg::*;
(
  // Clock
  input  wire logic         core_clk,
  // Events toward the controller
  output logic              frame_valid,
  output logic              frame_good,
  output logic              ack_valid,
  output logic [ERR_W-1:0]  ack_err_bits,
  output logic              rate_up_ok,
  output logic              rate_up_fail,
  output logic              link_req_valid,
  output logic [CALL_W-1:0] link_req_call,
  output logic              link_resp,
  output logic              attempt_miss,
  // Broadcast bytes from the radio
  output logic              bcast_in_valid,
  output logic [BC_W-1:0]   bcast_in_data,
  input  wire logic         bcast_in_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] pls_q;
  assign {attempt_miss, link_resp, link_req_valid, rate_up_fail,
          rate_up_ok, ack_valid, frame_valid} = pls_q;
  initial
  begin
    {pls_q, frame_good, ack_err_bits} = 11'h000;
    link_req_call  = 32'h0;
    {bcast_in_valid, bcast_in_data} = 9'h000;
  end
  // Qualifiers turn over when idle so stale values never look valid
  task automatic ev(input int k, input int n, input logic [31:0] v);
    @(posedge core_clk);
    pls_q         <= 7'(1 << k);
    frame_good    <= v[0];
    ack_err_bits  <= v[ERR_W-1:0];
    link_req_call <= v;
    repeat (n) @(posedge core_clk);
    pls_q         <= 7'h00;
    frame_good    <= ~v[0];
    ack_err_bits  <= ~v[ERR_W-1:0];
    link_req_call <= ~v;
  endtask
  // Byte held until taken; the wait is bounded
  task automatic push(input logic [BC_W-1:0] b);
    @(posedge core_clk);
    bcast_in_valid <= 1'b1;
    bcast_in_data  <= b;
    #1;
    for (int t = 0; t < 8 && bcast_in_ready !== 1'b1; t++)
      @(posedge core_clk) #1;
    @(posedge core_clk);
    bcast_in_valid <= 1'b0;
    bcast_in_data  <= ~b;
  endtask
endmodule
`default_nettype wire

// *** tb/arl_link_ctrl_bench.sv ***
// Self-checking bench of the rate-adaptive ARQ link controller
`default_nettype none
module arl_link_ctrl_bench
  import arl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRM = 0, ACK = 1, UOK = 2, UFL = 3, REQ = 4, RSP = 5;
  localparam int MISS = 6;
  logic              core_clk, rst_n, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic              frame_valid, frame_good, ack_valid, rate_up_ok;
  logic [ERR_W-1:0]  ack_err_bits;
  logic              rate_up_fail, link_req_valid, link_resp, attempt_miss;
  logic [CALL_W-1:0] link_req_call, remote_call_out;
  logic              bcast_in_valid, bcast_in_ready, bcast_out_valid;
  logic [BC_W-1:0]   bcast_in_data, bcast_out_data;
  logic              bcast_out_ready, manual_tx_req, manual_tx_grant;
  logic              mailbox_tx_owner, bcast_tx_allowed, ack_accept;
  logic              link_timeout;
  logic [1:0]        link_rate;
  logic [4:0]        link_state;
  int                err_count, checks;

  arl_link_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
    .frame_good(frame_good), .ack_valid(ack_valid),
    .ack_err_bits(ack_err_bits), .rate_up_ok(rate_up_ok),
    .rate_up_fail(rate_up_fail), .link_req_valid(link_req_valid),
    .link_req_call(link_req_call), .link_resp(link_resp),
    .attempt_miss(attempt_miss), .bcast_in_valid(bcast_in_valid),
    .bcast_in_data(bcast_in_data), .bcast_in_ready(bcast_in_ready),
    .bcast_out_valid(bcast_out_valid), .bcast_out_data(bcast_out_data),
    .bcast_out_ready(bcast_out_ready), .manual_tx_req(manual_tx_req),
    .manual_tx_grant(manual_tx_grant), .mailbox_tx_owner(mailbox_tx_owner),
    .bcast_tx_allowed(bcast_tx_allowed), .link_rate(link_rate),
    .link_state(link_state), .remote_call_out(remote_call_out),
    .ack_accept(ack_accept), .link_timeout(link_timeout));
  arl_remote rem (.core_clk(core_clk), .frame_valid(frame_valid),
    .frame_good(frame_good), .ack_valid(ack_valid),
    .ack_err_bits(ack_err_bits), .rate_up_ok(rate_up_ok),
    .rate_up_fail(rate_up_fail), .link_req_valid(link_req_valid),
    .link_req_call(link_req_call), .link_resp(link_resp),
    .attempt_miss(attempt_miss), .bcast_in_valid(bcast_in_valid),
    .bcast_in_data(bcast_in_data), .bcast_in_ready(bcast_in_ready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // Event pulses are judged in the one cycle they stand
  task automatic ev(input int k, input int n, input logic [31:0] v);
    rem.ev(k, n, v);
    #1;
  endtask
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask
  task automatic cmd(input logic [31:0] c, input arl_state_e s);
    wr(OFF_CMD, c);
    settle;
    chk(32'(link_state), 32'(s));
  endtask
  task automatic t_regs;
    rd(OFF_STATUS, 32'h1);
    rd(OFF_DOWN, 32'h6);
    rd(OFF_UP, 32'h3);
    rd(OFF_TRIES, 32'h2);
    rd(OFF_TMO, 32'h28);
    rd(OFF_FUZZ, 32'h3);
    rd(8'h3c, 32'h0);
    wr(OFF_TMO, 32'h5);
    rd(OFF_TMO, 32'h1e);
  endtask
  task automatic t_linking;
    wr(OFF_REMOTE, 32'h1234);
    cmd(32'h3, ST_LINKING);
    chk(remote_call_out, 32'h1234);
    ev(MISS, 29, 0);
    chk(32'(link_state), 32'(ST_LINKING));
    ev(MISS, 1, 0);
    chk(32'(link_timeout), 32'h1);
    chk(32'(link_state), 32'(ST_STANDBY));
  endtask
  task automatic t_rates;
    wr(OFF_OWN, 32'ha5);
    ev(REQ, 1, 32'h5a);
    chk(32'(link_state), 32'(ST_STANDBY));
    ev(REQ, 1, 32'ha5);
    chk(32'(link_state), 32'(ST_LINKED));
    ev(FRM, 3, 1);
    chk(32'(link_rate), 32'(RATE_200));
    ev(UFL, 1, 0);
    chk(32'(link_rate), 32'(RATE_200));
    ev(UFL, 1, 0);
    chk(32'(link_rate), 32'(RATE_100));
    ev(FRM, 2, 1);
    chk(32'(link_rate), 32'(RATE_100));
    ev(FRM, 1, 1);
    chk(32'(link_rate), 32'(RATE_200));
    ev(UOK, 1, 0);
    ev(FRM, 3, 1);
    chk(32'(link_rate), 32'(RATE_300));
    ev(FRM, 5, 0);
    chk(32'(link_rate), 32'(RATE_300));
    ev(FRM, 1, 0);
    chk(32'(link_rate), 32'(RATE_200));
  endtask
  task automatic t_acks;
    ev(ACK, 1, 3);
    chk(32'(ack_accept), 32'h1);
    wr(OFF_FUZZ, 32'h1);
    ev(ACK, 1, 2);
    chk(32'(ack_accept), 32'h0);
    ev(ACK, 1, 1);
    chk(32'(ack_accept), 32'h1);
    ev(FRM, 1, 1);
    ev(FRM, 29, 0);
    chk(32'(link_timeout), 32'h0);
    ev(FRM, 1, 0);
    chk(32'(link_timeout), 32'h1);
  endtask
  task automatic t_cmds;
    cmd(32'h8, ST_CMD);
    cmd(32'h3, ST_LINKING);
    ev(RSP, 1, 0);
    chk(32'(link_state), 32'(ST_LINKED));
    cmd(32'h4, ST_STANDBY);
    cmd(32'h8, ST_CMD);
    cmd(32'h10, ST_MONITOR);
    cmd(32'h8, ST_CMD);
  endtask
  // Out side stalls while four bytes fill the buffer
  task automatic t_bcast;
    wr(OFF_CTRL, 32'h1);
    cmd(32'h1, ST_STANDBY);
    for (int i = 0; i < 4; i++)
      rem.push(8'(8'h30 + i));
    settle;
    chk(32'(bcast_in_ready), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      chk(32'(bcast_out_data), 32'(8'h30 + i));
      @(posedge core_clk);
      bcast_out_ready <= 1'b1;
      @(posedge core_clk);
      bcast_out_ready <= 1'b0;
      settle;
    end
    chk(32'(bcast_out_valid), 32'h0);
    wr(OFF_CTRL, 32'h3);
    manual_tx_req <= 1'b1;
    settle;
    chk(32'({manual_tx_grant, mailbox_tx_owner, bcast_tx_allowed}),
        32'h2);
    wr(OFF_CTRL, 32'h0);
    settle;
    chk(32'({manual_tx_grant, bcast_tx_allowed, bcast_in_ready}),
        32'h6);
  endtask
  task automatic end_sim;
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #50000;
    err_count++;
    end_sim;
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, bcast_out_ready, manual_tx_req} = 5'h00;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_linking;
    t_rates;
    t_acks;
    t_cmds;
    t_bcast;
    end_sim;
  end
endmodule
`default_nettype wire
